// ### rtl/tsc_task_switch.sv
`default_nettype none
module tsc_task_switch (
    input wire logic mclk_in,                        // core clock, 40 MHz
    input wire logic rst_n_in,                       // async reset, active low
    input wire logic cmd_valid_in,                   // command strobe
    input wire logic [3:0] cmd_op_in,                // tsc_op_e code
    input wire logic [31:0] cmd_data_in,             // operand / flags image / address
    input wire logic desc_gate_in,                   // reference went through a task gate
    input wire logic [1:0] desc_table_in,            // table of the reference
    input wire logic [3:0] desc_type_in,             // type field of target task block
    input wire logic [15:0] desc_sel_in,             // selector of target task block
    input wire logic [31:0] desc_base_in,            // base of target task block
    input wire logic [31:0] desc_limit_in,           // limit of target task block
    input wire logic [2:0] desc_slot_in,             // storage slot of target block
    input wire logic [31:0] lin_addr_in,             // linear address being translated
    output logic busy_out,                           // issue blocked
    output logic done_out,                           // switch finished pulse
    output logic exc_valid_out,                      // exception pulse
    output logic [7:0] exc_vector_out,               // exception number
    output logic desc_wr_out,                        // descriptor type rewrite pulse
    output logic [15:0] desc_wr_sel_out,             // selector rewritten
    output logic [3:0] desc_wr_type_out,             // new type field
    output logic [15:0] task_register_out,           // current task selector
    output logic [31:0] tr_base_out,                 // hidden base
    output logic [31:0] tr_limit_out,                // hidden limit
    output logic [15:0] back_link_out,               // previous task selector
    output logic nested_flag_out,                    // flags word bit 14
    output logic virtual8086_flag_out,               // flags word bit 17
    output logic [31:0] machine_control_reg_out,     // machine control register
    output logic [31:0] fault_address_reg_out,       // page fault linear address
    output logic [31:0] directory_base_reg_out,      // page directory base
    output logic tlb_flush_out,                      // flush cached entries pulse
    output logic [31:0] dir_entry_addr_out,          // directory entry physical address
    output logic [31:0] stack_ptr_out                // stack pointer for new level
);
    tsc_pkg::tsc_state_e state, next_state;
    tsc_pkg::tsc_op_e op;
    tsc_mem_if ram ();

    logic [tsc_pkg::CNT_W-1:0] cnt;
    logic [tsc_pkg::WORD_W-1:0] word, prev_word;
    logic [tsc_pkg::SLOT_W-1:0] cur_slot, new_slot;
    logic [15:0] new_sel;
    logic [31:0] new_base, new_limit, ip_q, ld_flags, ld_dbr, flags_image;
    logic [15:0] ld_link;
    logic [3:0] new_type;
    logic nesting, ret_sw, ld_trap;
    logic accept, pe, tsb_type, start_sw, fmt32, busy_hit, type_bad, limit_bad, check_fail;
    logic [2:0] stack_word;

    assign op = tsc_pkg::tsc_op_e'(cmd_op_in);
    assign accept = cmd_valid_in && (state == tsc_pkg::ST_IDLE);
    assign pe = machine_control_reg_out[tsc_pkg::PE_BIT];
    assign tsb_type = (desc_type_in == tsc_pkg::TYPE_AVAIL32) || (desc_type_in == tsc_pkg::TYPE_BUSY32) ||
                      (desc_type_in == tsc_pkg::TYPE_AVAIL16) || (desc_type_in == tsc_pkg::TYPE_BUSY16);
    // real mode never switches tasks
    assign start_sw = pe && (((op == tsc_pkg::OP_FAR_JMP || op == tsc_pkg::OP_FAR_CALL) &&
                              desc_table_in != tsc_pkg::TBL_IDT && (desc_gate_in || tsb_type)) ||
                             (op == tsc_pkg::OP_INTR && desc_table_in == tsc_pkg::TBL_IDT && desc_gate_in) ||
                             (op == tsc_pkg::OP_INTERRUPT_RETURN_OP && nested_flag_out));
    assign stack_word = tsc_pkg::W_STACK0 + {1'b0, cmd_data_in[1:0]};
    assign prev_word = word - 3'h1;

    assign fmt32 = (new_type == tsc_pkg::TYPE_AVAIL32) || (new_type == tsc_pkg::TYPE_BUSY32);
    assign busy_hit = !ret_sw && (new_type == tsc_pkg::TYPE_BUSY32 || new_type == tsc_pkg::TYPE_BUSY16);
    // a return goes back to a block that is still marked busy
    assign type_bad = !(fmt32 || new_type == tsc_pkg::TYPE_AVAIL16 || new_type == tsc_pkg::TYPE_BUSY16);
    assign limit_bad = fmt32 ? (new_limit <= tsc_pkg::LIMIT_MIN32) : (new_limit <= tsc_pkg::LIMIT_MIN16);
    assign check_fail = busy_hit || type_bad || limit_bad;

    always_comb
    begin
        flags_image = 32'h0000_0000;
        flags_image[tsc_pkg::NESTED_BIT] = nested_flag_out;
        flags_image[tsc_pkg::VM_BIT] = virtual8086_flag_out;
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            tsc_pkg::ST_IDLE:
            begin
                if (accept && start_sw)
                    next_state = tsc_pkg::ST_CHECK;
                else if (accept && op == tsc_pkg::OP_PRIV_CHG && cmd_data_in[1:0] != tsc_pkg::LEVEL_USER)
                    next_state = tsc_pkg::ST_STACK;
            end
            tsc_pkg::ST_CHECK: next_state = check_fail ? tsc_pkg::ST_IDLE : tsc_pkg::ST_SAVE;
            tsc_pkg::ST_SAVE: next_state = (word == tsc_pkg::SAVE_LAST) ? tsc_pkg::ST_LOAD : tsc_pkg::ST_SAVE;
            tsc_pkg::ST_LOAD: next_state = (word == tsc_pkg::LOAD_DONE) ? tsc_pkg::ST_COMMIT : tsc_pkg::ST_LOAD;
            tsc_pkg::ST_COMMIT: next_state = tsc_pkg::ST_PAD;
            tsc_pkg::ST_PAD: next_state = (cnt >= tsc_pkg::SWITCH_LAST) ? tsc_pkg::ST_IDLE : tsc_pkg::ST_PAD;
            tsc_pkg::ST_STACK: next_state = tsc_pkg::ST_IDLE;
            default: next_state = tsc_pkg::ST_IDLE;
        endcase
    end

    // sequencer, word counter and latched request
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= tsc_pkg::ST_IDLE;
            cnt <= '0;
            word <= '0;
            new_slot <= '0;
            new_sel <= 16'h0000;
            new_base <= 32'h0000_0000;
            new_limit <= 32'h0000_0000;
            new_type <= 4'h0;
            ip_q <= 32'h0000_0000;
            nesting <= 1'b0;
            ret_sw <= 1'b0;
            ld_link <= 16'h0000;
            ld_flags <= 32'h0000_0000;
            ld_dbr <= 32'h0000_0000;
            ld_trap <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            busy_out <= (next_state != tsc_pkg::ST_IDLE);
            cnt <= (state == tsc_pkg::ST_IDLE) ? '0 : cnt + 1'b1;
            word <= (state != next_state) ? '0 : word + 3'h1;
            if (accept && start_sw)
            begin
                new_slot <= desc_slot_in;
                new_sel <= desc_sel_in;
                new_base <= desc_base_in;
                new_limit <= desc_limit_in;
                new_type <= desc_type_in;
                ip_q <= cmd_data_in;
                nesting <= (op == tsc_pkg::OP_FAR_CALL) || (op == tsc_pkg::OP_INTR);
                ret_sw <= (op == tsc_pkg::OP_INTERRUPT_RETURN_OP);
            end
            if (state == tsc_pkg::ST_LOAD && word != '0)
            begin
                case (prev_word)
                    tsc_pkg::W_LINK: ld_link <= ram.rdata[15:0];
                    tsc_pkg::W_FLAGS: ld_flags <= ram.rdata;
                    tsc_pkg::W_DIRBASE: ld_dbr <= ram.rdata;
                    tsc_pkg::W_TRAP: ld_trap <= ram.rdata[tsc_pkg::TRAP_BIT];
                    default: ld_trap <= ld_trap;
                endcase
            end
        end
    end

    // outgoing state goes to the current block, link into the incoming one on a call or interrupt
    always_comb
    begin
        ram.we = 1'b0;
        ram.addr = {cur_slot, stack_word};
        ram.wdata = 32'h0000_0000;
        if (state == tsc_pkg::ST_SAVE)
        begin
            ram.we = 1'b1;
            case (word)
                3'h0:
                begin
                    ram.addr = {cur_slot, tsc_pkg::W_FLAGS};
                    ram.wdata = flags_image;
                end
                3'h1:
                begin
                    ram.addr = {cur_slot, tsc_pkg::W_DIRBASE};
                    ram.wdata = directory_base_reg_out;
                end
                3'h2:
                begin
                    ram.addr = {cur_slot, tsc_pkg::W_IP};
                    ram.wdata = ip_q;
                end
                default:
                begin
                    ram.we = nesting;
                    ram.addr = {new_slot, tsc_pkg::W_LINK};
                    ram.wdata = {16'h0000, task_register_out};
                end
            endcase
        end
        else if (state == tsc_pkg::ST_LOAD)
        begin
            ram.addr = {new_slot, word};
        end
    end

    tsc_state_ram u_ram (
        .clk_in(mclk_in),
        .ram_in(ram.mem)
    );

    // flags word and machine control register
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            nested_flag_out <= 1'b0;
            virtual8086_flag_out <= 1'b0;
            machine_control_reg_out <= tsc_pkg::MCR_RESET;
        end
        else if (state == tsc_pkg::ST_COMMIT)
        begin
            nested_flag_out <= nesting ? 1'b1 : ld_flags[tsc_pkg::NESTED_BIT];
            virtual8086_flag_out <= ld_flags[tsc_pkg::VM_BIT];
            machine_control_reg_out[tsc_pkg::TS_BIT] <= 1'b1;
        end
        else if (accept && !start_sw)
        begin
            if (op == tsc_pkg::OP_INTR)
                nested_flag_out <= 1'b0;
            else if (op == tsc_pkg::OP_INTERRUPT_RETURN_OP || op == tsc_pkg::OP_FLAG_POP_OP)
                nested_flag_out <= cmd_data_in[tsc_pkg::NESTED_BIT];
            if (op == tsc_pkg::OP_MOV_CR0)
                machine_control_reg_out <= cmd_data_in;
        end
    end

    // task register, hidden part and link
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            task_register_out <= 16'h0000;
            tr_base_out <= 32'h0000_0000;
            tr_limit_out <= 32'h0000_0000;
            back_link_out <= 16'h0000;
            cur_slot <= '0;
        end
        else if (state == tsc_pkg::ST_COMMIT)
        begin
            task_register_out <= new_sel;
            tr_base_out <= new_base;
            tr_limit_out <= new_limit;
            back_link_out <= ld_link;
            cur_slot <= new_slot;
        end
        else if (accept && op == tsc_pkg::OP_LOAD_TR)
        begin
            // first switch saves into this block
            task_register_out <= desc_sel_in;
            tr_base_out <= desc_base_in;
            tr_limit_out <= desc_limit_in;
            cur_slot <= desc_slot_in;
        end
    end

    // paging control registers
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fault_address_reg_out <= 32'h0000_0000;
            directory_base_reg_out <= tsc_pkg::DBR_RESET;
            tlb_flush_out <= 1'b0;
            dir_entry_addr_out <= 32'h0000_0000;
        end
        else
        begin
            tlb_flush_out <= 1'b0;
            // directory base page number, then directory index
            dir_entry_addr_out <= {directory_base_reg_out[31:tsc_pkg::PAGE_OFFS_W],
                                   lin_addr_in[31:tsc_pkg::DIR_IDX_LSB], 2'b00};
            if (accept && (op == tsc_pkg::OP_PAGE_FAULT || op == tsc_pkg::OP_MOV_CR2))
                fault_address_reg_out <= cmd_data_in;
            if (accept && op == tsc_pkg::OP_MOV_CR3)
            begin
                directory_base_reg_out <= {cmd_data_in[31:tsc_pkg::PAGE_OFFS_W], 12'h000};
                tlb_flush_out <= 1'b1;
            end
            else if (state == tsc_pkg::ST_COMMIT)
            begin
                directory_base_reg_out <= {ld_dbr[31:tsc_pkg::PAGE_OFFS_W], 12'h000};
                tlb_flush_out <= (ld_dbr[31:tsc_pkg::PAGE_OFFS_W] !=
                                  directory_base_reg_out[31:tsc_pkg::PAGE_OFFS_W]);
            end
        end
    end

    // exceptions, busy marking, completion, stack pointer
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            exc_valid_out <= 1'b0;
            exc_vector_out <= 8'h00;
            desc_wr_out <= 1'b0;
            desc_wr_sel_out <= 16'h0000;
            desc_wr_type_out <= 4'h0;
            done_out <= 1'b0;
            stack_ptr_out <= 32'h0000_0000;
        end
        else
        begin
            exc_valid_out <= 1'b0;
            desc_wr_out <= 1'b0;
            done_out <= (state == tsc_pkg::ST_PAD) && (next_state == tsc_pkg::ST_IDLE);
            if (state == tsc_pkg::ST_CHECK && check_fail)
            begin
                exc_valid_out <= 1'b1;
                exc_vector_out <= tsc_pkg::VEC_GP;
            end
            else if (state == tsc_pkg::ST_COMMIT && ld_trap)
            begin
                exc_valid_out <= 1'b1;
                exc_vector_out <= tsc_pkg::VEC_DEBUG;
            end
            else if (accept && op == tsc_pkg::OP_FP_OP && machine_control_reg_out[tsc_pkg::TS_BIT] &&
                     machine_control_reg_out[tsc_pkg::MP_BIT])
            begin
                exc_valid_out <= 1'b1;
                exc_vector_out <= tsc_pkg::VEC_NOCOPROC;
            end
            if (state == tsc_pkg::ST_COMMIT && !ret_sw)
            begin
                desc_wr_out <= 1'b1;
                desc_wr_sel_out <= new_sel;
                desc_wr_type_out <= fmt32 ? tsc_pkg::TYPE_BUSY32 : tsc_pkg::TYPE_BUSY16;
            end
            if (state == tsc_pkg::ST_STACK)
                stack_ptr_out <= ram.rdata;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_fp_hazard;
        accept && op == tsc_pkg::OP_FP_OP && machine_control_reg_out[tsc_pkg::TS_BIT] &&
        machine_control_reg_out[tsc_pkg::MP_BIT];
    endsequence
    sequence s_commit_nesting;
        state == tsc_pkg::ST_COMMIT && nesting;
    endsequence

    a_fp_not_avail: assert property (s_fp_hazard |=> exc_valid_out && exc_vector_out == tsc_pkg::VEC_NOCOPROC)
        else $error("missing coprocessor exception");
    a_busy_ref_gp: assert property (state == tsc_pkg::ST_CHECK && busy_hit |=> exc_valid_out &&
        exc_vector_out == tsc_pkg::VEC_GP ##1 !busy_out)
        else $error("busy block not refused");
    a_nested_link_set: assert property (s_commit_nesting |=> nested_flag_out && desc_wr_out)
        else $error("nested flag or busy mark missing");
    a_busy_type_code: assert property (desc_wr_out |-> desc_wr_type_out == tsc_pkg::TYPE_BUSY32 ||
        desc_wr_type_out == tsc_pkg::TYPE_BUSY16)
        else $error("bad busy type code");
    a_switch_sets_ts: assert property (state == tsc_pkg::ST_COMMIT |=> machine_control_reg_out[tsc_pkg::TS_BIT])
        else $error("task switched flag not set");
    a_switch_duration: assert property (done_out |-> $past(cnt) == tsc_pkg::SWITCH_LAST)
        else $error("switch length wrong");
    a_dbr_aligned: assert property (directory_base_reg_out[tsc_pkg::PAGE_OFFS_W-1:0] == '0)
        else $error("directory base not page aligned");
    a_cr3_flush: assert property (accept && op == tsc_pkg::OP_MOV_CR3 |=> tlb_flush_out)
        else $error("no flush on directory base load");
    a_fault_capture: assert property (accept && op == tsc_pkg::OP_PAGE_FAULT |=>
        fault_address_reg_out == $past(cmd_data_in))
        else $error("fault address not captured");
    a_intr_clears_nt: assert property (accept && op == tsc_pkg::OP_INTR && !start_sw |=> !nested_flag_out)
        else $error("nested flag kept on plain interrupt");
    a_tr_hidden_load: assert property (state == tsc_pkg::ST_COMMIT |=> task_register_out == $past(new_sel) &&
        tr_base_out == $past(new_base))
        else $error("task register hidden part stale");
endmodule
`default_nettype wire

// ### rtl/tsc_pkg.sv
`default_nettype none
package tsc_pkg;
    localparam int DATA_W = 32;
    localparam int SLOT_W = 3;
    localparam int WORD_W = 3;
    localparam int ADDR_W = SLOT_W + WORD_W;
    localparam int DEPTH = 1 << ADDR_W;

    // command port operations
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_FAR_JMP = 4'h1,
        OP_FAR_CALL = 4'h2,
        OP_INTR = 4'h3,
        OP_INTERRUPT_RETURN_OP = 4'h4,
        OP_FLAG_POP_OP = 4'h5,
        OP_LOAD_TR = 4'h6,
        OP_MOV_CR0 = 4'h7,
        OP_MOV_CR2 = 4'h8,
        OP_MOV_CR3 = 4'h9,
        OP_PAGE_FAULT = 4'hA,
        OP_PRIV_CHG = 4'hB,
        OP_FP_OP = 4'hC
    } tsc_op_e;

    localparam logic [1:0] TBL_GDT = 2'h0;
    localparam logic [1:0] TBL_LDT = 2'h1;
    localparam logic [1:0] TBL_IDT = 2'h2;
    localparam logic [1:0] LEVEL_USER = 2'h3;

    // descriptor type field codes
    localparam logic [3:0] TYPE_AVAIL32 = 4'h9;
    localparam logic [3:0] TYPE_BUSY32 = 4'hB;
    localparam logic [3:0] TYPE_AVAIL16 = 4'h1;
    localparam logic [3:0] TYPE_BUSY16 = 4'h3;
    localparam logic [31:0] LIMIT_MIN32 = 32'h0000_0064;
    localparam logic [31:0] LIMIT_MIN16 = 32'h0000_002B;

    // bit positions
    localparam int NESTED_BIT = 14;
    localparam int VM_BIT = 17;
    localparam int PE_BIT = 0;
    localparam int MP_BIT = 1;
    localparam int TS_BIT = 3;
    localparam int TRAP_BIT = 0;
    localparam int PAGE_OFFS_W = 12;
    localparam int DIR_IDX_LSB = 22;
    localparam logic [31:0] MCR_RESET = 32'h0000_0000;
    localparam logic [31:0] DBR_RESET = 32'h0000_0000;

    // word layout inside one task state block
    localparam logic [2:0] W_LINK = 3'h0;
    localparam logic [2:0] W_FLAGS = 3'h1;
    localparam logic [2:0] W_DIRBASE = 3'h2;
    localparam logic [2:0] W_TRAP = 3'h3;
    localparam logic [2:0] W_STACK0 = 3'h4;
    localparam logic [2:0] W_IP = 3'h7;
    localparam logic [2:0] SAVE_LAST = 3'h3;
    localparam logic [2:0] LOAD_DONE = 3'h4;

    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_NOCOPROC = 8'h07;
    localparam logic [7:0] VEC_GP = 8'h0D;

    localparam int SWITCH_TIME_NS = 17000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SWITCH_CYCLES = (SWITCH_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (SWITCH_TIME_NS / CLK_PERIOD_NS);
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CHECK = 3'h1,
        ST_SAVE = 3'h3,
        ST_LOAD = 3'h2,
        ST_COMMIT = 3'h6,
        ST_PAD = 3'h7,
        ST_STACK = 3'h4
    } tsc_state_e;
endpackage
`default_nettype wire

// ### rtl/tsc_mem_if.sv
`default_nettype none
interface tsc_mem_if;
    logic we;
    logic [tsc_pkg::ADDR_W-1:0] addr;
    logic [tsc_pkg::DATA_W-1:0] wdata;
    logic [tsc_pkg::DATA_W-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/tsc_state_ram.sv
`default_nettype none
module tsc_state_ram (
    input wire logic clk_in,    // core clock
    tsc_mem_if.mem ram_in       // controller side
);
    logic [tsc_pkg::DATA_W-1:0] store [0:tsc_pkg::DEPTH-1];

    // read data registered; contents undefined until written
    always_ff @(posedge clk_in)
    begin
        if (ram_in.we)
        begin
            store[ram_in.addr] <= ram_in.wdata;
        end
        ram_in.rdata <= store[ram_in.addr];
    end
endmodule
`default_nettype wire

// ### dv/task_switch_control_bench.sv
`default_nettype none
module task_switch_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_n_in, cmd_valid_in, desc_gate_in, busy_out, done_out, exc_valid_out, desc_wr_out;
    logic nested_flag_out, virtual8086_flag_out, tlb_flush_out, flush, exc;
    logic [1:0] desc_table_in;
    logic [2:0] desc_slot_in;
    logic [3:0] cmd_op_in, desc_type_in, desc_wr_type_out, wtype;
    logic [7:0] exc_vector_out;
    logic [15:0] desc_sel_in, desc_wr_sel_out, task_register_out, back_link_out;
    logic [31:0] cmd_data_in, desc_base_in, desc_limit_in, lin_addr_in, tr_base_out, tr_limit_out;
    logic [31:0] machine_control_reg_out, fault_address_reg_out, directory_base_reg_out;
    logic [31:0] dir_entry_addr_out, stack_ptr_out;
    int fails, num_checks, n;

    tsc_task_switch uut (.*);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // pulses sampled from the first falling edge on, a pulse lives one cycle only
    task automatic cmd(input logic [3:0] op, input logic [31:0] d);
        cmd_op_in = op;
        cmd_data_in = d;
        cmd_valid_in = 1'b1;
        flush = 1'b0;
        exc = 1'b0;
        @(negedge mclk_in);
        cmd_valid_in = 1'b0;
        repeat (4)
        begin
            flush = flush | tlb_flush_out;
            exc = exc | exc_valid_out;
            @(negedge mclk_in);
        end
    endtask

    task automatic sw(input logic [3:0] op, input logic [3:0] ty, input logic [15:0] sel);
        desc_type_in = ty;
        desc_sel_in = sel;
        wtype = 4'h0;
        cmd(op, 32'h0000_0100);
        n = 0;
        while (busy_out === 1'b1 && n < 1000)
        begin
            @(negedge mclk_in);
            n++;
            if (desc_wr_out === 1'b1)
                wtype = desc_wr_type_out;
        end
        if (n >= 1000)
        begin
            fails++;
            complete_run();
        end
    endtask

    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    initial
    begin
        rst_n_in = 0; cmd_valid_in = 0; cmd_op_in = 0; cmd_data_in = 0; desc_gate_in = 0; desc_sel_in = 0;
        desc_table_in = tsc_pkg::TBL_GDT; desc_type_in = 0; desc_base_in = 32'h0004_0000;
        desc_limit_in = 32'h0000_0065; desc_slot_in = 3'h1; lin_addr_in = 32'hFFC0_1234;
        fails = 0; num_checks = 0; wtype = 0; flush = 0; exc = 0; n = 0;
        repeat (2) @(negedge mclk_in);
        rst_n_in = 1'b1;
        chk("mcr reset", 32'h0000_0000, machine_control_reg_out);
        sw(tsc_pkg::OP_FAR_CALL, tsc_pkg::TYPE_AVAIL32, 16'h0028);
        chk("tr in real mode", 32'h0000_0000, 32'(task_register_out));
        cmd(tsc_pkg::OP_MOV_CR3, 32'h1234_5FFF);
        chk("dir base", 32'h1234_5000, directory_base_reg_out);
        chk("flush", 32'h0000_0001, 32'(flush));
        chk("dir entry", 32'h1234_5FFC, dir_entry_addr_out);
        cmd(tsc_pkg::OP_PAGE_FAULT, 32'hDEAD_BEEF);
        chk("fault addr", 32'hDEAD_BEEF, fault_address_reg_out);
        cmd(tsc_pkg::OP_MOV_CR0, 32'h0000_0002);
        cmd(tsc_pkg::OP_FP_OP, 32'h0000_0000);
        chk("fp no ts", 32'h0000_0000, 32'(exc_vector_out));
        chk("fp no ts pulse", 32'h0000_0000, 32'(exc));
        desc_sel_in = 16'h0028;
        cmd(tsc_pkg::OP_LOAD_TR, 32'h0000_0000);
        chk("tr load", 32'h0000_0028, 32'(task_register_out));
        cmd(tsc_pkg::OP_MOV_CR0, 32'h0000_0003);
        chk("mcr pe", 32'h0000_0003, machine_control_reg_out);
        // jump into the current block: its flags and base get saved before being read back
        sw(tsc_pkg::OP_FAR_JMP, tsc_pkg::TYPE_AVAIL32, 16'h0028);
        chk("mcr ts", 32'h0000_000B, machine_control_reg_out);
        chk("jmp nested", 32'h0000_0000, 32'(nested_flag_out));
        sw(tsc_pkg::OP_FAR_CALL, tsc_pkg::TYPE_AVAIL32, 16'h0028);
        chk("switch length", 32'h0000_0001, 32'(n > 600 && n < 700));
        chk("done", 32'h0000_0001, 32'(done_out));
        chk("busy type", 32'(tsc_pkg::TYPE_BUSY32), 32'(wtype));
        chk("busy sel", 32'h0000_0028, 32'(desc_wr_sel_out));
        chk("tr", 32'h0000_0028, 32'(task_register_out));
        chk("tr base", 32'h0004_0000, tr_base_out);
        chk("tr limit", 32'h0000_0065, tr_limit_out);
        chk("back link", 32'h0000_0028, 32'(back_link_out));
        chk("nested", 32'h0000_0001, 32'(nested_flag_out));
        chk("vm", 32'h0000_0000, 32'(virtual8086_flag_out));
        chk("dir base loaded", 32'h1234_5000, directory_base_reg_out);
        cmd(tsc_pkg::OP_FP_OP, 32'h0000_0000);
        chk("fp exc", 32'h0000_0007, 32'(exc_vector_out));
        chk("fp exc pulse", 32'h0000_0001, 32'(exc));
        sw(tsc_pkg::OP_FAR_CALL, tsc_pkg::TYPE_BUSY32, 16'h0030);
        chk("busy ref", 32'h0000_000D, 32'(exc_vector_out));
        chk("tr kept", 32'h0000_0028, 32'(task_register_out));
        desc_limit_in = 32'h0000_0064;
        sw(tsc_pkg::OP_FAR_CALL, tsc_pkg::TYPE_AVAIL32, 16'h0030);
        chk("limit exc", 32'h0000_0001, 32'(exc));
        chk("limit tr kept", 32'h0000_0028, 32'(task_register_out));
        desc_limit_in = 32'h0000_0065;
        desc_table_in = tsc_pkg::TBL_IDT;
        cmd(tsc_pkg::OP_INTR, 32'h0000_0000);
        chk("intr nested", 32'h0000_0000, 32'(nested_flag_out));
        cmd(tsc_pkg::OP_FLAG_POP_OP, 32'h0000_4000);
        chk("flag_pop_op nested", 32'h0000_0001, 32'(nested_flag_out));
        desc_gate_in = 1'b1;
        sw(tsc_pkg::OP_INTR, tsc_pkg::TYPE_AVAIL32, 16'h0030);
        chk("intr switch tr", 32'h0000_0030, 32'(task_register_out));
        chk("intr back link", 32'h0000_0028, 32'(back_link_out));
        sw(tsc_pkg::OP_INTERRUPT_RETURN_OP, tsc_pkg::TYPE_BUSY32, 16'h0028);
        chk("interrupt_return_op tr", 32'h0000_0028, 32'(task_register_out));
        chk("interrupt_return_op no mark", 32'h0000_0000, 32'(wtype));
        desc_gate_in = 1'b0;
        desc_table_in = tsc_pkg::TBL_GDT;
        sw(tsc_pkg::OP_FAR_JMP, tsc_pkg::TYPE_AVAIL16, 16'h0038);
        chk("busy type 16", 32'(tsc_pkg::TYPE_BUSY16), 32'(wtype));
        complete_run();
    end
endmodule
`default_nettype wire
